// >>> iams_ack_timer.sv
// Interrupt acknowledge and macro service timing unit with Avalon-MM registers
`timescale 1ns/10ps
`include "iams_regs.svh"

module iams_ack_timer #(
  parameter int NSRC = 16
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // Avalon-MM slave
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  output logic      [1:0]                avs_response,
  // Request sources
  input  wire logic [NSRC-1:0]           src_req,
  input  wire iams_pkg::iams_req_t       req_info,
  input  wire iams_pkg::iams_wait_t      wait_info,
  // CPU sequencer
  input  wire logic                      insn_end,
  input  wire logic                      insn_holdoff,
  input  wire logic                      swi_trap,
  input  wire logic                      vectored_return_op,
  input  wire logic                      context_switch_return_op,
  input  wire logic                      wdog_dedicated_wr,
  input  wire logic [7:0]                wdog_dedicated_data,
  output logic                           ack_start,
  output logic                           ack_done,
  output logic                           busy,
  output logic      [7:0]                ack_latency
);

  iams_pkg::iams_state_t state_q, state_d;
  iams_pkg::iams_req_t   cur_q;
  logic [7:0]  cnt_q;
  logic [7:0]  hold_q;
  logic [7:0]  lat_q;
  logic [7:0]  isp_q;
  logic [7:0]  wdog_q;
  logic [15:0] mask_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic        nmi_run_q;
  logic [2:0]  nmi_lvl_q;

  // Stall sums
  wire logic [7:0] n_stack  = 8'(wait_info.stack_addr) + 8'(wait_info.stack_acc);
  wire logic [7:0] m_vec    = 8'(wait_info.vec_addr) + 8'(wait_info.vec_acc);
  wire logic [7:0] n_data   = 8'(wait_info.data_addr) + 8'(wait_info.data_acc);
  wire logic [7:0] br_stall = 8'(wait_info.branch_stall);

  // Acknowledge latency
  wire logic       vt_slow  = req_info.vec_mem == iams_pkg::IAMS_MEM_SLOW;
  wire logic       br_slow  = req_info.branch_mem == iams_pkg::IAMS_MEM_SLOW;
  wire logic [7:0] vec_base =
      (req_info.stack_mem == iams_pkg::IAMS_MEM_SLOW) ? 8'(`IAMS_VEC_SLOW + 8'(n_stack << 2)) :
      (req_info.stack_mem == iams_pkg::IAMS_MEM_PERI_RAM) ? `IAMS_VEC_PERI :
      `IAMS_VEC_FAST;
  wire logic [7:0] odd_add  = (req_info.stack_mem == iams_pkg::IAMS_MEM_PERI_RAM &&
                               req_info.sp_odd) ? `IAMS_ODD_SP_ADD : 8'h00;
  wire logic [7:0] vec_lat  = 8'(vec_base + (vt_slow ? `IAMS_VT_SLOW_ADD : 8'h00)
                              + (br_slow ? `IAMS_BR_SLOW_ADD : 8'h00)
                              + (vt_slow ? 8'(m_vec << 1) : 8'h00)
                              + (br_slow ? br_stall : 8'h00) + odd_add);
  wire logic [7:0] cs_lat   = 8'(`IAMS_CS_FAST + (br_slow ? `IAMS_BR_SLOW_ADD : 8'h00)
                              + (vt_slow ? m_vec : 8'h00)
                              + (br_slow ? br_stall : 8'h00));

  // Macro service latency
  wire logic       d_slow   = req_info.ms_data_mem == iams_pkg::IAMS_MEM_SLOW;
  wire logic       d_fast   = req_info.ms_data_mem == iams_pkg::IAMS_MEM_FAST_RAM;
  wire logic [7:0] a_base   = !req_info.ms_two_byte ? `IAMS_MS_A1 :
                              req_info.ms_to_sfr ? `IAMS_MS_A2_TOSFR : `IAMS_MS_A2_TOMEM;
  wire logic [7:0] b_base   = 8'(`IAMS_MS_B_BASE + (req_info.ms_to_sfr ? 8'h01 : 8'h00)
                              + (d_fast ? 8'h00 : 8'h02));
  wire logic [7:0] c_base   = d_fast ? `IAMS_MS_C_FAST : `IAMS_MS_C_SLOW;
  wire logic [7:0] ring_add = !req_info.ms_ring ? 8'h00 :
                              8'(`IAMS_MS_RING_ADD +
                                 (req_info.ms_ring_zero ? `IAMS_MS_RING0_ADD : 8'h00));
  wire logic [7:0] ms_odd   = (req_info.ms_two_byte && req_info.ms_odd_addr &&
                               !d_slow) ? `IAMS_MS_ODD_ADD : 8'h00;
  wire logic [7:0] ms_slow  = !d_slow ? 8'h00 : req_info.ms_two_byte ?
                              8'(8'd4 + 8'(n_data << 1)) : n_data;
  wire logic [7:0] ms_zero  = req_info.ms_count_zero ? `IAMS_MS_ZERO_ADD : 8'h00;
  logic [7:0] ms_lat;
  always_comb begin
    case (req_info.ms_type)
      iams_pkg::IAMS_MS_SIMPLE:  ms_lat = 8'(a_base + ms_odd + ms_slow + ms_zero);
      iams_pkg::IAMS_MS_POINTER: ms_lat = 8'(b_base + ms_odd + ms_slow + ms_zero);
      iams_pkg::IAMS_MS_PATTERN: ms_lat = 8'(c_base + ring_add + ms_odd + ms_slow + ms_zero);
      default: ms_lat = req_info.ms_count_zero ? `IAMS_MS_CNT_Z : `IAMS_MS_CNT_NZ;
    endcase
  end

  // Acceptance gating
  wire logic [NSRC-1:0] live  = src_req & ~mask_q[NSRC-1:0];
  wire logic any_req  = req_info.nmi || req_info.macro || (|live);
  wire logic hold_on  = hold_q != 8'h00 || insn_holdoff;
  wire logic nmi_ok   = !nmi_run_q || req_info.nmi_high && req_info.prio_lvl > nmi_lvl_q;
  wire logic may_take = !hold_on && (req_info.macro ||
                        (req_info.nmi ? nmi_ok : |live));
  wire logic accept   = state_q == iams_pkg::IAMS_WAIT_END && insn_end && may_take;
  wire logic done_now = cnt_q == 8'h01 &&
                        (state_q == iams_pkg::IAMS_ACK || state_q == iams_pkg::IAMS_MACRO);

  always_comb begin
    state_d = state_q;
    case (state_q)
      iams_pkg::IAMS_IDLE:     if (any_req) state_d = iams_pkg::IAMS_RESOLVE;
      iams_pkg::IAMS_RESOLVE:  if (cnt_q == 8'h01) state_d = iams_pkg::IAMS_WAIT_END;
      iams_pkg::IAMS_WAIT_END: begin
        if (!any_req) state_d = iams_pkg::IAMS_IDLE;
        else if (accept) state_d = req_info.macro ? iams_pkg::IAMS_MACRO : iams_pkg::IAMS_ACK;
      end
      iams_pkg::IAMS_ACK,
      iams_pkg::IAMS_MACRO:    if (done_now) state_d = iams_pkg::IAMS_IDLE;
      default:                 state_d = iams_pkg::IAMS_IDLE;
    endcase
  end

  wire logic [7:0] take_lat = req_info.macro ? ms_lat :
                              req_info.ctx_switch ? cs_lat : vec_lat;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= iams_pkg::IAMS_IDLE;
      cnt_q   <= 8'h00;
      cur_q   <= '0;
      lat_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q == iams_pkg::IAMS_IDLE && any_req) begin
        cnt_q <= `IAMS_RESOLVE_CLK;
      end else if (accept) begin
        cnt_q <= take_lat;
        cur_q <= req_info;
        lat_q <= take_lat;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // Hold-off window after deferring instructions; traps are exempt
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 8'h00;
    end else if (insn_holdoff && !swi_trap) begin
      hold_q <= `IAMS_HOLDOFF_CLK;
    end else if (hold_q != 8'h00) begin
      hold_q <= hold_q - 8'h01;
    end
  end

  // In-service priority: one bit per level, set on acknowledge, cleared by returns
  wire logic vec_ack = done_now && state_q == iams_pkg::IAMS_ACK;
  wire logic [7:0] lvl_bit = 8'h01 << cur_q.prio_lvl;
  logic [7:0] isp_d;
  always_comb begin
    isp_d = isp_q;
    if (vectored_return_op || context_switch_return_op) begin
      isp_d = isp_q & (isp_q - 8'h01);
    end
    if (vec_ack) begin
      isp_d = isp_d | lvl_bit;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      isp_q     <= 8'h00;
      nmi_run_q <= 1'b0;
      nmi_lvl_q <= 3'h0;
    end else begin
      isp_q <= isp_d;
      if (vec_ack && cur_q.nmi) begin
        nmi_run_q <= 1'b1;
        nmi_lvl_q <= cur_q.prio_lvl;
      end else if (vectored_return_op) begin
        nmi_run_q <= 1'b0;
      end
    end
  end

  // Avalon-MM slave: one wait cycle on reads, writes take effect at once
  wire logic sel_mask = avs_address == `IAMS_OFF_MASK;
  wire logic wr_mask  = avs_write && sel_mask;
  wire logic mapped   = avs_address <= `IAMS_OFF_LAST && avs_address[1:0] == 2'b00;
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      `IAMS_OFF_CTRL:   rd_mux = {24'h0, hold_q};
      `IAMS_OFF_STATUS: rd_mux = {16'h0, lat_q, 4'h0, nmi_run_q, state_q};
      `IAMS_OFF_INSVC:  rd_mux = {24'h0, isp_q};
      `IAMS_OFF_WDOG:   rd_mux = {24'h0, wdog_q};
      `IAMS_OFF_MASK:   rd_mux = {16'h0, mask_q};
      `IAMS_OFF_WAIT:   rd_mux = {24'h0, cnt_q};
      default:          rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_q   <= `IAMS_RST_MASK;
      wdog_q   <= `IAMS_RST_WDOG;
      rdata_q  <= 32'h0;
      rvalid_q <= 1'b0;
    end else begin
      if (wr_mask && avs_byteenable[0]) mask_q[7:0] <= avs_writedata[7:0];
      if (wr_mask && avs_byteenable[1]) mask_q[15:8] <= avs_writedata[15:8];
      // Bus writes to the watchdog mode and in-service registers are dropped
      if (wdog_dedicated_wr) wdog_q <= wdog_dedicated_data;
      rvalid_q <= avs_read && !rvalid_q;
      rdata_q  <= rd_mux;
    end
  end

  assign avs_waitrequest = avs_read && !rvalid_q;
  assign avs_readdata    = rdata_q;
  assign avs_response    = mapped ? 2'b00 : 2'b10;
  assign ack_start       = accept;
  assign ack_done        = done_now;
  assign busy            = state_q == iams_pkg::IAMS_ACK || state_q == iams_pkg::IAMS_MACRO;
  assign ack_latency     = lat_q;

endmodule : iams_ack_timer

// >>> iams_ack_timer_asserts.sv
// Port checker of the acknowledge timing unit
`timescale 1ns/10ps
module iams_ack_timer_asserts #(
  parameter int NSRC = 16
) (
  // Clock, reset and bus
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Sequencer side
  input wire logic       insn_end,
  input wire logic       insn_holdoff,
  input wire logic       swi_trap,
  input wire logic       ack_start,
  input wire logic       ack_done,
  input wire logic       busy,
  input wire logic [7:0] ack_latency
);
  logic [7:0] run_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Cycles since acceptance
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) run_q <= 8'h00;
    else if (ack_start) run_q <= 8'h01;
    else if (busy) run_q <= run_q + 8'h01;
  end
  a_accept_at_end: assert property (ack_start |-> insn_end && !insn_holdoff)
    else $error("acceptance off an instruction boundary");
  a_no_start_busy: assert property (busy |-> !ack_start)
    else $error("acceptance while busy");
  a_done_latency: assert property (ack_done |-> run_q == ack_latency)
    else $error("done not at the latency");
  a_resolve_gap: assert property (ack_done |=> !ack_start [*8])
    else $error("acceptance inside resolve time");
  a_holdoff_block: assert property (insn_holdoff && !swi_trap |-> !ack_start [*8])
    else $error("acceptance inside hold-off");
  a_start_pulse: assert property (ack_start |=> busy && !ack_start)
    else $error("start not a pulse followed by busy");
  a_busy_hold: assert property (busy && !ack_done |=> busy)
    else $error("busy dropped before done");
  a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered in first cycle");
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_unmapped_err: assert property ((avs_read || avs_write) && avs_address > 8'h18
    |-> avs_response == 2'b10)
    else $error("unmapped access not refused");
endmodule : iams_ack_timer_asserts

bind iams_ack_timer iams_ack_timer_asserts #(.NSRC(NSRC)) u_iams_ack_timer_asserts (
  .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .insn_end(insn_end), .insn_holdoff(insn_holdoff), .swi_trap(swi_trap),
  .ack_start(ack_start), .ack_done(ack_done), .busy(busy), .ack_latency(ack_latency));

// >>> iams_cpu_model.sv
// Instruction sequencer model: boundaries and deferring ends
`timescale 1ns/10ps
module iams_cpu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Self-branching poll select
  input  wire logic hold_on,
  // Sequencer outputs
  output logic      insn_end,
  output logic      insn_holdoff
);
  logic [1:0] ph_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ph_q <= 2'h0;
    else ph_q <= ph_q + 2'h1;
  end
  assign insn_end     = (ph_q == 2'h3);
  assign insn_holdoff = insn_end & hold_on;
endmodule : iams_cpu_model

// >>> iams_pkg.sv
// Types of the acknowledge timing unit
package iams_pkg;
  typedef enum logic [1:0] {
    IAMS_MEM_FAST_ROM = 2'b00,
    IAMS_MEM_PERI_RAM = 2'b01,
    IAMS_MEM_FAST_RAM = 2'b10,
    IAMS_MEM_SLOW = 2'b11
  } iams_mem_t;
  typedef enum logic [1:0] {
    IAMS_MS_SIMPLE  = 2'b00,
    IAMS_MS_POINTER = 2'b01,
    IAMS_MS_PATTERN = 2'b10,
    IAMS_MS_COUNTER = 2'b11
  } iams_ms_t;
  typedef enum logic [2:0] {
    IAMS_IDLE     = 3'b000,
    IAMS_RESOLVE  = 3'b001,
    IAMS_WAIT_END = 3'b010,
    IAMS_ACK      = 3'b011,
    IAMS_MACRO    = 3'b100
  } iams_state_t;
  // Per-request descriptor presented with a request
  typedef struct packed {
    logic       nmi;
    logic       nmi_high;
    logic       macro;
    logic       ctx_switch;
    iams_mem_t  vec_mem;
    iams_mem_t  branch_mem;
    iams_mem_t  stack_mem;
    logic       sp_odd;
    iams_ms_t   ms_type;
    logic       ms_two_byte;
    logic       ms_to_sfr;
    iams_mem_t  ms_data_mem;
    logic       ms_odd_addr;
    logic       ms_count_zero;
    logic       ms_ring;
    logic       ms_ring_zero;
    logic [2:0] prio_lvl;
  } iams_req_t;
  // Stall figures: address-phase plus access-phase per byte
  typedef struct packed {
    logic [3:0] stack_addr;
    logic [3:0] stack_acc;
    logic [3:0] vec_addr;
    logic [3:0] vec_acc;
    logic [3:0] branch_stall;
    logic [3:0] data_addr;
    logic [3:0] data_acc;
  } iams_wait_t;
endpackage : iams_pkg

// >>> iams_regs.svh
// Register offsets, reset values and timing counts of the acknowledge timing unit
`ifndef IAMS_REGS_SVH
`define IAMS_REGS_SVH
// Byte offsets on the Avalon-MM slave
`define IAMS_OFF_CTRL      8'h00
`define IAMS_OFF_STATUS    8'h04
`define IAMS_OFF_INSVC     8'h08
`define IAMS_OFF_WDOG      8'h0c
`define IAMS_OFF_MASK      8'h10
`define IAMS_OFF_WAIT      8'h14
`define IAMS_OFF_LAST      8'h18
// Reset values
`define IAMS_RST_MASK      16'hffff
`define IAMS_RST_WDOG      8'h00
// Timing counts, in clocks
`define IAMS_RESOLVE_CLK   8'd8
`define IAMS_HOLDOFF_CLK   8'd8
`define IAMS_VEC_FAST      8'd26
`define IAMS_VEC_PERI      8'd29
`define IAMS_VEC_SLOW      8'd37
`define IAMS_CS_FAST       8'd22
`define IAMS_BR_SLOW_ADD   8'd1
`define IAMS_VT_SLOW_ADD   8'd4
`define IAMS_ODD_SP_ADD    8'd4
`define IAMS_MS_A1         8'd24
`define IAMS_MS_A2_TOMEM   8'd25
`define IAMS_MS_A2_TOSFR   8'd26
`define IAMS_MS_B_BASE     8'd33
`define IAMS_MS_C_FAST     8'd49
`define IAMS_MS_C_SLOW     8'd53
`define IAMS_MS_ODD_ADD    8'd4
`define IAMS_MS_ZERO_ADD   8'd1
`define IAMS_MS_RING_ADD   8'd4
`define IAMS_MS_RING0_ADD  8'd7
`define IAMS_MS_CNT_NZ     8'd17
`define IAMS_MS_CNT_Z      8'd25
`endif

// >>> testbench.sv
// Self-checking testbench of the acknowledge timing unit
`timescale 1ns/10ps
`include "iams_regs.svh"
module testbench;
  logic clk, resetn, avs_read, avs_write, avs_waitrequest, swi_trap, hold_on;
  logic vret, cret, wdog_wr, insn_end, insn_holdoff, ack_start, ack_done, busy;
  logic [7:0] avs_address, wdog_data, ack_latency;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0] avs_response, rs;
  logic [15:0] src_req;
  iams_pkg::iams_req_t req_info;
  iams_pkg::iams_wait_t wait_info;
  int err_total, comparisons;
  iams_ack_timer u_iams_ack_timer (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .src_req(src_req), .req_info(req_info),
    .wait_info(wait_info), .insn_end(insn_end), .insn_holdoff(insn_holdoff),
    .swi_trap(swi_trap), .vectored_return_op(vret), .context_switch_return_op(cret),
    .wdog_dedicated_wr(wdog_wr), .wdog_dedicated_data(wdog_data), .ack_start(ack_start),
    .ack_done(ack_done), .busy(busy), .ack_latency(ack_latency));
  iams_cpu_model u_iams_cpu_model (.clk(clk), .resetn(resetn), .hold_on(hold_on),
    .insn_end(insn_end), .insn_holdoff(insn_holdoff));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a; avs_writedata <= d; avs_write <= we; avs_read <= !we;
    #1;
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk); #1;
    end
    rd = avs_readdata; rs = avs_response;
    @(posedge clk);
    avs_read <= 1'b0; avs_write <= 1'b0;
  endtask : bus
  task ret_op(input logic ctx);
    @(posedge clk);
    vret <= !ctx; cret <= ctx;
    @(posedge clk);
    vret <= 1'b0; cret <= 1'b0;
  endtask : ret_op
  task automatic pick(input int i, output iams_pkg::iams_req_t r,
                      output iams_pkg::iams_wait_t w, output int e);
    r = '0; w = '0;
    r.stack_mem = iams_pkg::IAMS_MEM_FAST_RAM; r.ms_data_mem = iams_pkg::IAMS_MEM_FAST_RAM;
    r.prio_lvl = 3'h1; r.macro = (i == 1 || i > 7);
    r.ms_two_byte = (i > 7 && i < 11);
    r.ms_type = (i == 12) ? iams_pkg::IAMS_MS_POINTER
              : (i > 12) ? iams_pkg::IAMS_MS_PATTERN : iams_pkg::IAMS_MS_SIMPLE;
    case (i)
      0: begin r.nmi = 1'b1; e = 26; end
      1: e = 24;
      2: e = 26;
      3: begin r.stack_mem = iams_pkg::IAMS_MEM_SLOW; w.stack_addr = 4'h1;
        w.stack_acc = 4'h2; e = 49; end
      4: begin r.stack_mem = iams_pkg::IAMS_MEM_PERI_RAM; r.sp_odd = 1'b1; e = 33; end
      5: begin r.vec_mem = iams_pkg::IAMS_MEM_SLOW; w.vec_acc = 4'h2; e = 34; end
      6: begin r.vec_mem = iams_pkg::IAMS_MEM_SLOW; w.vec_addr = 4'h2;
        r.ctx_switch = 1'b1; e = 24; end
      7: begin r.branch_mem = iams_pkg::IAMS_MEM_SLOW; w.branch_stall = 4'h3; e = 30; end
      8: e = 25;
      9: begin r.ms_to_sfr = 1'b1; e = 26; end
      10: begin r.ms_odd_addr = 1'b1; e = 29; end
      11: begin r.ms_count_zero = 1'b1; e = 25; end
      12: e = 33;
      13: e = 49;
      14: begin r.ms_data_mem = iams_pkg::IAMS_MEM_SLOW; e = 53; end
      15: begin r.ms_ring = 1'b1; e = 53; end
      17: begin r.ms_type = iams_pkg::IAMS_MS_COUNTER; e = 17; end
      default: begin r.ms_ring = 1'b1; r.ms_ring_zero = 1'b1; e = 60; end
    endcase
  endtask : pick
  task automatic run(input int i, input logic ret, input logic held);
    iams_pkg::iams_req_t r;
    iams_pkg::iams_wait_t w;
    int e, k, n;
    pick(i, r, w, e);
    @(posedge clk);
    req_info <= r; wait_info <= w; src_req <= {15'h0, !(r.nmi || r.macro)};
    hold_on <= held;
    n = 0;
    repeat (held ? 40 : 0) begin
      @(posedge clk); #1; n += (ack_start === 1'b1);
    end
    if (held) chk(n, 0);
    @(posedge clk);
    hold_on <= 1'b0;
    k = 0;
    do begin @(posedge clk); #1; k++; end while (ack_start !== 1'b1 && k < 200);
    @(posedge clk);
    src_req <= '0; req_info <= '0;
    n = 1;
    #1;
    while (ack_done !== 1'b1 && n < 200) begin
      @(posedge clk); #1; n++;
    end
    chk(n, e);
    chk({24'h0, ack_latency}, e);
    if (ret) ret_op(r.ctx_switch);
    $display("test case %0d done", i);
  endtask : run
  task test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done;
  end
  initial begin
    {resetn, avs_read, avs_write, swi_trap, hold_on, vret, cret, wdog_wr} = '0;
    avs_address = 8'h00; avs_writedata = '0; wdog_data = 8'h00; src_req = '0;
    req_info = '0; wait_info = '0; err_total = 0; comparisons = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, `IAMS_OFF_MASK, 32'h0); chk(rd, 32'h0000ffff);
    bus(1'b1, `IAMS_OFF_INSVC, 32'hff); bus(1'b0, `IAMS_OFF_INSVC, 32'h0); chk(rd, 32'h0);
    bus(1'b1, `IAMS_OFF_WDOG, 32'h5a); bus(1'b0, `IAMS_OFF_WDOG, 32'h0); chk(rd, 32'h0);
    @(posedge clk); wdog_wr <= 1'b1; wdog_data <= 8'h5a;
    @(posedge clk); wdog_wr <= 1'b0;
    bus(1'b0, `IAMS_OFF_WDOG, 32'h0); chk(rd, 32'h5a);
    bus(1'b0, 8'h40, 32'h0); chk({30'h0, rs}, 32'h2); chk(rd, 32'h0);
    $display("test registers done");
    run(0, 1'b0, 1'b0);
    run(1, 1'b0, 1'b0);
    ret_op(1'b0);
    bus(1'b1, `IAMS_OFF_MASK, 32'h0);
    run(2, 1'b1, 1'b1);
    for (int i = 2; i < 18; i++) run(i, !(i > 7), 1'b0);
    run(2, 1'b0, 1'b0);
    bus(1'b0, `IAMS_OFF_INSVC, 32'h0); chk(rd, 32'h2);
    for (int k = 0; k < 8 && rd !== 32'h0; k++) begin
      ret_op(1'b0);
      bus(1'b0, `IAMS_OFF_INSVC, 32'h0);
    end
    chk(rd, 32'h0);
    $display("test recovery done");
    test_done;
  end
endmodule : testbench
